// ### verilog/mmt_mailbox.sv
/*
 * Message mailbox transfer block: output mailbox for host commands,
 * input mailbox for replies, status refreshed at host I/O refresh.
 *
 * Register map (byte offsets, one aligned word each):
 *   0x00 control: bit 0 run, bit 1 fieldbus communication off
 *   0x04 status copy: bit 12 output box full, bit 13 reply pending
 *   0x08 write descriptor: code 31:16, unit 15:12, BCD count 11:0
 *   0x0c write data: low 16 bits, first word first
 *   0x10 spare command word, reads as zero
 *   0x14 reply data: a read pops one reply word when one waits
 *   0x18 result: bit 0 transfer ok, bit 1 request syntax error
 *   0x1c refresh: any write copies live status to the host view
 *
 * Write sequence: descriptor, then exactly count data words; the
 * success flag rises with the last word and the box is then held
 * until the consumer strobes consumption.
 *
 * Assumes an APB master on core_clk and a message consumer that
 * strobes consumption and delivers reply words.
 * Assumes the host polls the result word after every message, since
 * a refused descriptor leaves no other trace.
 */
// Decided for this implementation: register access over APB and the register addresses.
// Notes on behaviour
// RULE1 - Commands in output box, replies in input box
// RULE2 - Control-command replies discarded automatically
// RULE3 - Host must drain non-control replies
// RULE4 - Full bit shown, refreshed only at refresh
// RULE5 - Host writes only when full bit clear
// RULE6 - Host writes at most once per scan
// RULE7 - Refuse write if full, stopped or disabled
// RULE8 - Success only when whole message accepted
// RULE9 - Syntax error raises error, clears success
// RULE10 - Host gives code zero, unit, BCD count
// RULE11 - Message from consecutive words, count long
// RULE12 - Reply pending bit, refreshed at refresh
// RULE13 - Full cleared after consumption, shown later
`timescale 1ns/10ps
`default_nettype none
`include "mmt_params.svh"
module mmt_mailbox (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Unit number strap, sampled continuously
    input wire logic [3:0] unit_number,
    // Message consumer (fieldbus side)
    output logic out_box_valid,
    output logic [15:0] out_box_word,
    output logic [7:0] out_box_length,
    input wire logic out_box_consumed,
    input wire logic reply_valid,
    input wire logic [15:0] reply_word,
    input wire logic reply_is_control,
    // Status copies
    output logic out_box_full_bit,
    output logic reply_pending_bit
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Write sequence state
    mmt_pkg::mmt_state_type state;
    mmt_pkg::mmt_state_type next_state;
    // Output mailbox array and its write and stream bookkeeping
    logic [15:0] cmd_mem [0:`MMT_DEPTH-1];
    logic [7:0] wr_count;
    logic [7:0] wr_length;
    logic [6:0] rd_index;
    // Host control bits and result flags
    logic [1:0] ctrl;
    logic transfer_ok_flag;
    logic request_syntax_error_flag;
    // Remaining words of a control reply being dropped
    logic [7:0] drain_len;
    // Link from the front end to the reply store
    mmt_box_if box ();

    // BCD word count decode, used for check and length
    function automatic logic [9:0] bcd_to_bin(input logic [11:0] bcd);
        bcd_to_bin = 10'(bcd[11:8]) * 10'h064 + 10'(bcd[7:4]) * 10'h00a + 10'(bcd[3:0]);
    endfunction : bcd_to_bin

    function automatic logic bcd_ok(input logic [11:0] bcd);
        bcd_ok = (bcd[11:8] < 4'ha) && (bcd[7:4] < 4'ha) && (bcd[3:0] < 4'ha);
    endfunction : bcd_ok

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Full-word compare on paddr: any other address, unaligned ones too,
    // answers with pslverr and leaves every register untouched
    wire access = psel && penable;
    wire wr_acc = access && pwrite;
    wire rd_acc = access && !pwrite;
    wire hit_ctrl = (paddr == `MMT_OFS_CTRL);
    wire hit_status = (paddr == `MMT_OFS_STATUS);
    wire hit_desc = (paddr == `MMT_OFS_WR_DESC);
    wire hit_data = (paddr == `MMT_OFS_WR_DATA);
    wire hit_cmd = (paddr == `MMT_OFS_WR_CMD);
    wire hit_rdata = (paddr == `MMT_OFS_RD_DATA);
    wire hit_result = (paddr == `MMT_OFS_RESULT);
    wire hit_refresh = (paddr == `MMT_OFS_REFRESH);
    wire mapped = hit_ctrl | hit_status | hit_desc | hit_data | hit_cmd
                | hit_rdata | hit_result | hit_refresh;

    // ------------------------------------------------------------------
    // Write request checks
    // ------------------------------------------------------------------
    // Descriptor: bits 31:16 control code, 15:12 unit, 11:0 BCD count
    wire [15:0] desc_code = pwdata[31:`MMT_DESC_CODE_LSB];
    wire [3:0] desc_unit = pwdata[15:12];
    // Count is decoded to ten bits so that counts from 256 up cannot wrap
    // back into the legal range; only the checked value is kept as length
    wire [9:0] desc_count = bcd_to_bin(pwdata[11:0]);
    wire [7:0] desc_len = desc_count[7:0];
    wire desc_syntax_ok = (desc_code == 16'h0000) && bcd_ok(pwdata[11:0])
                        && (desc_unit == unit_number) && (desc_count != 10'h000)
                        && (desc_count <= {2'h0, `MMT_MAX_WORDS}); // RULE10
    // Run and disable are read live, never from the refreshed copy
    wire run_on = ctrl[`MMT_CTRL_RUN_BIT];
    wire comm_off = ctrl[`MMT_CTRL_DIS_BIT];
    // Box is taken from descriptor onward so a stale full bit cannot race
    wire box_busy = (state != mmt_pkg::MMT_IDLE);
    wire desc_take = wr_acc && hit_desc;
    wire accept = desc_take && desc_syntax_ok && !box_busy && run_on && !comm_off; // RULE7
    wire data_take = wr_acc && hit_data && (state == mmt_pkg::MMT_LOAD);
    wire last_word = data_take && (wr_count == wr_length - 8'h01);
    wire consumed = out_box_consumed && (state == mmt_pkg::MMT_HELD);

    // Write-side sequence
    // Data words outside the load phase are ignored, so a refused
    // descriptor followed by its data words leaves the box untouched,
    // unless a load is already in progress and takes those words
    always_comb begin
        next_state = state;
        unique case (state)
            mmt_pkg::MMT_IDLE: begin
                if (accept) begin
                    next_state = mmt_pkg::MMT_LOAD;
                end
            end
            mmt_pkg::MMT_LOAD: begin
                if (last_word) begin
                    next_state = mmt_pkg::MMT_HELD; // RULE11
                end
            end
            mmt_pkg::MMT_HELD: begin
                if (consumed) begin
                    next_state = mmt_pkg::MMT_IDLE; // RULE13
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Reply path: drop control-command replies
    // ------------------------------------------------------------------
    // A reply whose first word is the control header is swallowed whole
    // The drop count is fixed, not read from the reply header; a longer
    // control reply would leak its tail into the input box
    // Words lost while the input box is full are not counted anywhere
    wire ctrl_head = reply_valid && (reply_is_control || reply_word == `MMT_CTRL_CMD_CODE);
    wire dropping = ctrl_head || (drain_len != 8'h00);
    assign box.push = reply_valid && !dropping && !box.full; // RULE1 RULE2
    assign box.push_word = reply_word;
    assign box.pop = rd_acc && hit_rdata && box.not_empty;

    // Reply store; it refuses nothing itself, the push above already
    // holds back while it is full
    mmt_reply_store u_store (
        .core_clk(core_clk),
        .resetn(resetn),
        .box(box)
    );

    // Read data selection
    // Read data is latched in the setup cycle, so a pop in the access
    // cycle cannot change what the host sees
    wire [31:0] status_word = {18'h00000, reply_pending_bit, out_box_full_bit, 12'h000};
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl}
                       : hit_status ? status_word
                       : hit_rdata ? {16'h0000, box.head_word}
                       : hit_result ? {30'h0, request_syntax_error_flag, transfer_ok_flag}
                       : 32'h00000000;

    // ------------------------------------------------------------------
    // Sequential state
    // ------------------------------------------------------------------
    // Message store for the output mailbox; no reset, read every cycle but valid only after a load
    always_ff @(posedge core_clk) begin
        if (data_take) begin
            cmd_mem[wr_count[6:0]] <= pwdata[15:0]; // RULE11
        end
    end

    // The output index wraps at the held length so the consumer sees the
    // message as a loop of exactly count words
    wire index_wrap = (rd_index == wr_length[6:0] - 7'h01); // RULE11

    // Sequence and counters
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= mmt_pkg::MMT_IDLE;
            wr_count <= 8'h00;
            wr_length <= 8'h00;
            rd_index <= 7'h00;
        end else begin
            state <= next_state;
            if (accept) begin
                wr_count <= 8'h00;
                wr_length <= desc_len;
            end else if (data_take) begin
                wr_count <= wr_count + 8'h01;
            end
            if (accept) begin
                rd_index <= 7'h00;
            end else if (out_box_valid && out_box_consumed) begin
                rd_index <= rd_index;
            end else if (state == mmt_pkg::MMT_HELD) begin
                rd_index <= index_wrap ? 7'h00 : rd_index + 7'h01;
            end
        end
    end

    // Consumer view of the held message: words stream round the box
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            out_box_valid <= 1'b0;
            out_box_word <= 16'h0000;
            out_box_length <= 8'h00;
        end else begin
            out_box_valid <= (next_state == mmt_pkg::MMT_HELD);
            out_box_word <= cmd_mem[rd_index];
            out_box_length <= wr_length;
        end
    end

    // Control bits and result flags; a new descriptor clears success and loads the error flag from its syntax check
    // A descriptor and a last data word never share a cycle, so the two
    // branches below cannot collide
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= `MMT_CTRL_RESET;
            transfer_ok_flag <= 1'b0;
            request_syntax_error_flag <= 1'b0;
        end else begin
            if (wr_acc && hit_ctrl) begin
                ctrl <= pwdata[1:0];
            end
            if (desc_take) begin
                transfer_ok_flag <= 1'b0; // RULE9
                request_syntax_error_flag <= !desc_syntax_ok; // RULE9
            end else if (last_word) begin
                transfer_ok_flag <= 1'b1; // RULE8
            end
        end
    end

    // Drain counter for a discarded control reply (fixed length)
    // A new control head restarts the count, even in mid-drain
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            drain_len <= 8'h00;
        end else if (ctrl_head) begin
            drain_len <= `MMT_DRAIN_CYCLES; // RULE2
        end else if (reply_valid && drain_len != 8'h00) begin
            drain_len <= drain_len - 8'h01;
        end
    end

    // Host copies change only on a refresh strobe, stale in between
    // Full is taken from next_state so a message consumed in the
    // refresh cycle already shows as free
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            out_box_full_bit <= 1'b0;
            reply_pending_bit <= 1'b0;
        end else if (wr_acc && hit_refresh) begin
            out_box_full_bit <= (next_state != mmt_pkg::MMT_IDLE); // RULE4 RULE13
            reply_pending_bit <= box.not_empty; // RULE12
        end
    end

    // APB answer: zero wait states, error on unmapped address
    // pready is registered from the setup cycle, which fixes every access
    // phase at one cycle; the bus never waits
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end
endmodule : mmt_mailbox
`default_nettype wire

// ### verilog/mmt_params.svh
/*
 * Constants of the message mailbox transfer block: register offsets, field
 * positions, reset values and sizes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MMT_PARAMS_SVH
`define MMT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on APB
// ----------------------------------------------------------------------
`define MMT_OFS_CTRL 12'h000
`define MMT_OFS_STATUS 12'h004
`define MMT_OFS_WR_DESC 12'h008
`define MMT_OFS_WR_DATA 12'h00c
`define MMT_OFS_WR_CMD 12'h010
`define MMT_OFS_RD_DATA 12'h014
`define MMT_OFS_RESULT 12'h018
`define MMT_OFS_REFRESH 12'h01c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MMT_CTRL_RUN_BIT 0
`define MMT_CTRL_DIS_BIT 1
`define MMT_ST_FULL_BIT 12
`define MMT_ST_PEND_BIT 13
`define MMT_RES_OK_BIT 0
`define MMT_RES_ERR_BIT 1
`define MMT_DESC_CODE_LSB 16

// ----------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------
`define MMT_MAX_WORDS 8'd128
`define MMT_DEPTH 128
`define MMT_REPLY_SLOTS 4
`define MMT_CTRL_RESET 2'h0
`define MMT_CTRL_CMD_CODE 16'h0310
`define MMT_DRAIN_CYCLES 8'h10

`endif

// ### verilog/mmt_pkg.sv
/*
 * Types shared by the mailbox transfer block.
 * Assumes the params header holds all numeric constants.
 */
package mmt_pkg;
    // Write-side sequence
    typedef enum logic [2:0] {
        MMT_IDLE = 3'b001,
        MMT_LOAD = 3'b010,
        MMT_HELD = 3'b100
    } mmt_state_type;
endpackage : mmt_pkg

// ### verilog/mmt_box_if.sv
/*
 * Interface between the mailbox front end and the reply store.
 * Assumes one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
interface mmt_box_if;
    logic push;
    logic [15:0] push_word;
    logic pop;
    logic [15:0] head_word;
    logic not_empty;
    logic full;
    modport store (input push, input push_word, input pop,
                   output head_word, output not_empty, output full);
    modport user (output push, output push_word, output pop,
                  input head_word, input not_empty, input full);
endinterface : mmt_box_if
`default_nettype wire

// ### verilog/mmt_reply_store.sv
/*
 * Input mailbox: word store for replies to be read by the host.
 * Assumes the user never pushes when full nor pops when empty.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mmt_params.svh"
module mmt_reply_store (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Store side
    mmt_box_if.store box
);
    logic [15:0] mem [0:`MMT_DEPTH-1];
    logic [6:0] wr_ptr;
    logic [6:0] rd_ptr;
    logic [7:0] count;

    // Head word and occupancy flags
    assign box.head_word = mem[rd_ptr];
    assign box.not_empty = (count != 8'h00);
    assign box.full = (count == `MMT_MAX_WORDS);

    // Storage array, no reset needed
    always_ff @(posedge core_clk) begin
        if (box.push) begin
            mem[wr_ptr] <= box.push_word;
        end
    end

    // Pointers and count
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= 7'h00;
            rd_ptr <= 7'h00;
            count <= 8'h00;
        end else begin
            wr_ptr <= wr_ptr + 7'(box.push);
            rd_ptr <= rd_ptr + 7'(box.pop);
            count <= count + 8'(box.push) - 8'(box.pop);
        end
    end
endmodule : mmt_reply_store
`default_nettype wire

// ### testbench/mmt_mailbox_props.sv
/* Port checker for the mailbox block.
   Assumes binding to mmt_mailbox, one clock. */
`timescale 1ns/10ps
`default_nettype none
module mmt_mailbox_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Mailbox side
    input wire logic out_box_valid,
    input wire logic [7:0] out_box_length,
    input wire logic out_box_consumed,
    input wire logic out_box_full_bit,
    input wire logic reply_pending_bit
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Refresh write; one spare cycle allowed for the copy to land
    wire refresh_wr = pready && pwrite && paddr == 12'h01c;
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_mapped: assert property (pready && paddr < 12'h020 |-> !pslverr)
        else $error("pslverr on mapped address");
    a_full_frozen: assert property (!refresh_wr && !$past(refresh_wr) |=>
        $stable(out_box_full_bit)) else $error("full bit moved");
    a_pend_frozen: assert property (!refresh_wr && !$past(refresh_wr) |=>
        $stable(reply_pending_bit)) else $error("pending bit moved");
    a_length_held: assert property (out_box_valid && $past(out_box_valid) |->
        $stable(out_box_length)) else $error("length changed");
    a_consume_frees: assert property (out_box_valid && out_box_consumed |->
        ##[1:3] !out_box_valid) else $error("box not freed");
    cover property (out_box_consumed);
    cover property (pready && pslverr);
    cover property (refresh_wr ##1 reply_pending_bit);
endmodule : mmt_mailbox_props
bind mmt_mailbox mmt_mailbox_props u_props (.core_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pready, .pslverr, .out_box_valid, .out_box_length, .out_box_consumed,
    .out_box_full_bit, .reply_pending_bit);
`default_nettype wire

// ### testbench/mmt_consumer_model.sv
/* Fieldbus-side consumer: takes the held message, answers with replies.
   Assumes one clock; six-word messages are control commands. */
`timescale 1ns/10ps
`default_nettype none
module mmt_consumer_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Output mailbox
    input wire logic out_box_valid,
    input wire logic [7:0] out_box_length,
    output logic out_box_consumed,
    // Reply words
    output logic reply_valid,
    output logic [15:0] reply_word,
    output logic reply_is_control
);
    int n;
    // Slow consumer, so that a second write meets a full box
    initial begin
        out_box_consumed = 1'b0;
        reply_valid = 1'b0;
        reply_word = 16'h0000;
        reply_is_control = 1'b0;
        forever begin
            @(posedge core_clk);
            if (resetn === 1'b1 && out_box_valid === 1'b1) begin
                n = (out_box_length == 8'd6) ? 17 : 2;
                repeat (100) @(posedge core_clk);
                out_box_consumed <= 1'b1;
                @(posedge core_clk);
                out_box_consumed <= 1'b0;
                for (int i = 0; i < n; i++) begin
                    reply_valid <= 1'b1;
                    reply_is_control <= (n == 17 && i == 0);
                    reply_word <= (n == 17 && i == 0) ? 16'h0310 : 16'ha5a0 + i[15:0];
                    @(posedge core_clk);
                end
                reply_valid <= 1'b0;
                reply_is_control <= 1'b0;
                reply_word <= ~reply_word; // No stale word left on the lines
            end
        end
    end
endmodule : mmt_consumer_model
`default_nettype wire

// ### testbench/message_mailbox_transfer_tb.sv
/* Self-checking bench for the mailbox block.
   Assumes the consumer model on the fieldbus side. */
`timescale 1ns/10ps
`default_nettype none
module message_mailbox_transfer_tb;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] unit_number;
    logic out_box_valid, out_box_consumed, reply_valid, reply_is_control;
    logic [15:0] out_box_word, reply_word;
    logic [7:0] out_box_length;
    logic out_box_full_bit, reply_pending_bit;
    int errors = 0;
    int samples_checked = 0;
    mmt_mailbox dut (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .unit_number, .out_box_valid, .out_box_word,
        .out_box_length, .out_box_consumed, .reply_valid, .reply_word,
        .reply_is_control, .out_box_full_bit, .reply_pending_bit);
    mmt_consumer_model partner (.core_clk, .resetn, .out_box_valid, .out_box_length,
        .out_box_consumed, .reply_valid, .reply_word, .reply_is_control);
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1) tally_and_finish();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic expect_rd(string nm, logic [11:0] a, logic [31:0] m, logic [31:0] ex);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, ex, q & m);
    endtask : expect_rd
    task automatic send(input logic [31:0] desc, input int nw);
        wr(12'h008, desc);
        for (int i = 0; i < nw; i++) wr(12'h00c, {16'h0, 16'hc000 + i[15:0]});
    endtask : send
    task automatic wait_free();
        int n = 0;
        while (out_box_valid === 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        chk("consumed", 32'h0, {31'h0, out_box_valid});
        repeat (25) @(posedge core_clk);
    endtask : wait_free
    task automatic t_accept();
        wr(12'h000, 32'h1);
        wr(12'h01c, 32'h0);
        expect_rd("full idle", 12'h004, 32'h1000, 32'h0);
        send(32'h1008, 8);
        expect_rd("ok", 12'h018, 32'h3, 32'h1);
        chk("word", 32'hc000, {16'h0, out_box_word & 16'hfff8});
        expect_rd("full stale", 12'h004, 32'h1000, 32'h0);
        chk("length", 32'h8, {24'h0, out_box_length});
        wr(12'h01c, 32'h0);
        expect_rd("full", 12'h004, 32'h1000, 32'h1000);
        send(32'h1002, 2);
        expect_rd("ok busy", 12'h018, 32'h3, 32'h0);
        wait_free();
        wr(12'h01c, 32'h0);
        expect_rd("status", 12'h004, 32'h3000, 32'h2000);
        expect_rd("reply0", 12'h014, 32'hffff, 32'ha5a0);
        expect_rd("reply1", 12'h014, 32'hffff, 32'ha5a1);
        wr(12'h01c, 32'h0);
        expect_rd("drained", 12'h004, 32'h2000, 32'h0);
        $display("test accept done");
    endtask : t_accept
    task automatic t_control();
        send(32'h1006, 6);
        expect_rd("ok ctl", 12'h018, 32'h3, 32'h1);
        chk("word ctl", 32'hc000, {16'h0, out_box_word & 16'hfff8});
        wait_free();
        wr(12'h01c, 32'h0);
        expect_rd("ctl dropped", 12'h004, 32'h2000, 32'h0);
        $display("test control done");
    endtask : t_control
    // Stopped, disabled, then malformed descriptors
    task automatic t_refuse();
        logic [31:0] dsc [8] = '{32'h1008, 32'h1008, 32'h11008, 32'h100a, 32'h2008,
                                 32'h1000, 32'h1129, 32'h1300};
        logic [1:0] ctl [8] = '{2'h0, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
        logic [1:0] res [8] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 8; i++) begin
            wr(12'h000, {30'h0, ctl[i]});
            send(dsc[i], 8);
            expect_rd("result", 12'h018, 32'h3, {30'h0, res[i]});
            chk("refused held", 32'h0, {31'h0, out_box_valid});
        end
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk("slverr", 32'h1, {31'h0, e});
        $display("test refuse done");
    endtask : t_refuse
    // Reset, then the scenarios in turn
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        unit_number = 4'h1;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        t_accept();
        t_control();
        t_refuse();
        tally_and_finish();
    end
endmodule : message_mailbox_transfer_tb
`default_nettype wire
